// ===== verilog/css_cfg.svh
/*
 * Constants of the count-source selection front end: rule summary, source
 * and mode codes, tick periods and derived cycle counts.
 * Assumes a 200 MHz core clock; included by the package and the modules.
 */
// Function
// - Phase A/B source counts pin pulses decoded per configured pulse input mode.
// - Phase A/B source allowed only in normal, frequency or rotation speed mode.
// - Internal ticks of 0.1, 1, 10 or 100 us counted, only in normal mode.
// - Cross source, peer normal: count each rising edge of peer match flag.
// - Cross source, peer PWM: count each rising edge of peer coincidence output.
// - Cross source only with own normal mode and peer normal or PWM mode.
// - Internal clock count equals elapsed time divided by tick period.
// - Internal ticks with coincidence output give an on-delay timer.
// - Pulse input mode only matters when the phase A/B source is selected.
`ifndef CSS_CFG_SVH
`define CSS_CFG_SVH

// ----------------------------------------------------------------------
// Clock and tick periods
// ----------------------------------------------------------------------
`define CSS_CLK_PERIOD_PS   5000
`define CSS_TICK0_PS        100000
`define CSS_TICK1_PS        1000000
`define CSS_TICK2_PS        10000000
`define CSS_TICK3_PS        100000000
`define CSS_TICK0_CYC       (`CSS_TICK0_PS / `CSS_CLK_PERIOD_PS)
`define CSS_TICK1_CYC       (`CSS_TICK1_PS / `CSS_CLK_PERIOD_PS)
`define CSS_TICK2_CYC       (`CSS_TICK2_PS / `CSS_CLK_PERIOD_PS)
`define CSS_TICK3_CYC       (`CSS_TICK3_PS / `CSS_CLK_PERIOD_PS)

// ----------------------------------------------------------------------
// Source codes
// ----------------------------------------------------------------------
`define CSS_SRC_PHASE       3'h0
`define CSS_SRC_INT0        3'h1
`define CSS_SRC_INT1        3'h2
`define CSS_SRC_INT2        3'h3
`define CSS_SRC_INT3        3'h4
`define CSS_SRC_PEER        3'h5

// ----------------------------------------------------------------------
// Operation mode codes
// ----------------------------------------------------------------------
`define CSS_MODE_NORMAL     3'h0
`define CSS_MODE_FREQ       3'h1
`define CSS_MODE_SPEED      3'h2
`define CSS_MODE_PULSE      3'h3
`define CSS_MODE_PWM        3'h4

// ----------------------------------------------------------------------
// Pulse input mode codes
// ----------------------------------------------------------------------
`define CSS_PIM_1X1         3'h0
`define CSS_PIM_1X1A        3'h1
`define CSS_PIM_1X2         3'h2
`define CSS_PIM_1X2A        3'h3
`define CSS_PIM_CWCCW       3'h4
`define CSS_PIM_2X1         3'h5
`define CSS_PIM_2X2         3'h6
`define CSS_PIM_2X4         3'h7

`endif

// ===== verilog/css_pkg.sv
/*
 * Types of the count-source selection front end.
 * Assumes css_cfg.svh is on the include path.
 */
`include "css_cfg.svh"

package css_pkg;
   typedef logic [2:0] css_src_type;
   typedef logic [2:0] css_mode_type;
   typedef logic [2:0] css_pim_type;
endpackage : css_pkg

// ===== verilog/css_tick_if.sv
/*
 * Interface carrying internal tick strobes from the tick generator to the
 * selector. Assumes both ends share one clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface css_tick_if;
   logic [3:0] tick;   // One-cycle strobe per period, index 0 is fastest.
   modport gen (output tick);
   modport use_ (input tick);
endinterface : css_tick_if

`default_nettype wire

// ===== verilog/css_tick_gen.sv
/*
 * Internal tick generator: four free-running dividers of the core clock.
 * Assumes a 200 MHz clock so every period is a whole number of cycles.
 */
`timescale 1ns/10ps
`default_nettype none
`include "css_cfg.svh"

module css_tick_gen #(
   parameter int CYC0 = `CSS_TICK0_CYC,
   parameter int CYC1 = `CSS_TICK1_CYC,
   parameter int CYC2 = `CSS_TICK2_CYC,
   parameter int CYC3 = `CSS_TICK3_CYC
) (
   // Clock and reset
   input wire logic  clock,
   input wire logic  resetn,
   // Tick strobes
   css_tick_if.gen   tk
);
   import css_pkg::*;

   localparam int CYC [4] = '{CYC0, CYC1, CYC2, CYC3};

   typedef struct packed {
      logic [3:0][24:0] cnt;
      logic [3:0]       tick;
   } css_tg_state_type;

   css_tg_state_type st_ff;
   css_tg_state_type nxt_st;

   // Each divider wraps after its period and strobes once per wrap.
   always_comb begin
      nxt_st = st_ff;
      for (int i = 0; i < 4; i++) begin
         if (st_ff.cnt[i] == 25'(CYC[i] - 1)) begin
            nxt_st.cnt[i]  = '0;
            nxt_st.tick[i] = 1'b1;
         end else begin
            nxt_st.cnt[i]  = st_ff.cnt[i] + 25'h0000001;
            nxt_st.tick[i] = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tk.tick = st_ff.tick;

   // Fastest tick recurs exactly every twenty cycles.
   chk_tick0_period: assert property (@(posedge clock) disable iff (!resetn)
      st_ff.tick[0] |=> !st_ff.tick[0] [*8] ##1 !st_ff.tick[0] [*8] ##1 !st_ff.tick[0] [*3]
      ##1 st_ff.tick[0])
      else $error("tick0 period wrong");
endmodule : css_tick_gen

`default_nettype wire

// ===== verilog/css_source_select.sv
/*
 * Count-source selection front end for one counter channel. Picks phase
 * A/B pins, one of four internal ticks or the peer channel's first
 * coincidence event, and emits one-cycle count pulses with a direction.
 * Assumes pins are asynchronous, peer signals come from the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
`include "css_cfg.svh"

module css_source_select (
   // Clock and reset
   input wire logic            clock,
   input wire logic            resetn,
   // Configuration
   input wire css_pkg::css_src_type  srcSel,
   input wire css_pkg::css_mode_type ownMode,
   input wire css_pkg::css_mode_type peerMode,
   input wire css_pkg::css_pim_type  pulseMode,
   input wire logic            countDownCmd,
   // External pulse pins
   input wire logic            phaseA,
   input wire logic            phaseB,
   // Peer channel events
   input wire logic            peer_match1_flag,
   input wire logic            peerCoinOut1,
   // Counter core side
   output logic                countPulse,
   output logic                countDown,
   output logic                srcIllegal
);
   import css_pkg::*;

   css_tick_if tk ();

   // ----------------------------------------------------------------------
   // Tick generator
   // ----------------------------------------------------------------------
   css_tick_gen u_tick (
      .clock  (clock),
      .resetn (resetn),
      .tk     (tk)
   );

   typedef struct packed {
      logic [1:0] syncA;
      logic [1:0] syncB;
      logic       prevA;
      logic       prevB;
      logic       prevPeer;
      logic       pulse;
      logic       down;
      logic       illegal;
   } css_state_type;

   css_state_type st_ff;
   css_state_type nxt_st;

   logic aNow;
   logic bNow;
   logic aRise;
   logic aFall;
   logic bRise;
   logic bFall;
   logic peerSig;
   logic srcOk;
   logic up;
   logic dn;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   // Only the second synchroniser stage feeds edge detection, so a
   // metastable first stage never reaches the decoder.
   always_comb begin
      nxt_st = st_ff;
      nxt_st.syncA = {st_ff.syncA[0], phaseA};
      nxt_st.syncB = {st_ff.syncB[0], phaseB};
      aNow  = st_ff.syncA[1];
      bNow  = st_ff.syncB[1];
      nxt_st.prevA = aNow;
      nxt_st.prevB = bNow;
      aRise = aNow & ~st_ff.prevA;
      aFall = ~aNow & st_ff.prevA;
      bRise = bNow & ~st_ff.prevB;
      bFall = ~bNow & st_ff.prevB;

      // Peer source follows the peer's mode; PWM uses the output pin.
      peerSig = (peerMode == `CSS_MODE_PWM) ? peerCoinOut1
                                            : peer_match1_flag;
      nxt_st.prevPeer = peerSig;

      // Legality of the chosen source against the modes.
      unique case (srcSel)
         `CSS_SRC_PHASE:
            srcOk = (ownMode == `CSS_MODE_NORMAL) || (ownMode == `CSS_MODE_FREQ)
                    || (ownMode == `CSS_MODE_SPEED);
         `CSS_SRC_INT0, `CSS_SRC_INT1, `CSS_SRC_INT2, `CSS_SRC_INT3:
            srcOk = (ownMode == `CSS_MODE_NORMAL);
         `CSS_SRC_PEER:
            srcOk = (ownMode == `CSS_MODE_NORMAL) && ((peerMode == `CSS_MODE_NORMAL)
                    || (peerMode == `CSS_MODE_PWM));
         default:
            srcOk = 1'b0;
      endcase

      // Phase decoding is consulted only for the pin source.
      up = 1'b0;
      dn = 1'b0;
      unique case (pulseMode)
         `CSS_PIM_1X1: begin
            up = aRise & ~(bNow | countDownCmd);
            dn = aFall & (bNow | countDownCmd);
         end
         `CSS_PIM_1X1A: begin
            up = aRise & ~countDownCmd;
            dn = aFall & countDownCmd;
         end
         `CSS_PIM_1X2: begin
            up = (aRise | aFall) & ~(bNow | countDownCmd);
            dn = (aRise | aFall) & (bNow | countDownCmd);
         end
         `CSS_PIM_1X2A: begin
            up = (aRise | aFall) & ~countDownCmd;
            dn = (aRise | aFall) & countDownCmd;
         end
         `CSS_PIM_CWCCW: begin
            up = aRise & ~bNow;
            dn = bRise & ~aNow;
         end
         `CSS_PIM_2X1: begin
            up = aRise & ~bNow;
            dn = aFall & ~bNow;
         end
         `CSS_PIM_2X2: begin
            up = (aRise & ~bNow) | (aFall & bNow);
            dn = (aRise & bNow) | (aFall & ~bNow);
         end
         `CSS_PIM_2X4: begin
            up = (aRise & ~bNow) | (aFall & bNow) | (bRise & aNow) | (bFall & ~aNow);
            dn = (aRise & bNow) | (aFall & ~bNow) | (bRise & ~aNow) | (bFall & aNow);
         end
      endcase

      // One pulse per qualifying event, only from a legal source.
      nxt_st.pulse   = 1'b0;
      nxt_st.down    = 1'b0;
      nxt_st.illegal = ~srcOk;
      if (srcOk) begin
         unique case (srcSel)
            `CSS_SRC_PHASE: begin
               nxt_st.pulse = up | dn;
               nxt_st.down  = dn & ~up;
            end
            `CSS_SRC_INT0: nxt_st.pulse = tk.tick[0];
            `CSS_SRC_INT1: nxt_st.pulse = tk.tick[1];
            `CSS_SRC_INT2: nxt_st.pulse = tk.tick[2];
            `CSS_SRC_INT3: nxt_st.pulse = tk.tick[3];
            `CSS_SRC_PEER: nxt_st.pulse = peerSig & ~st_ff.prevPeer;
            default:       nxt_st.pulse = 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign countPulse = st_ff.pulse;
   assign countDown  = st_ff.down;
   assign srcIllegal = st_ff.illegal;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   sequence peerRise;
      srcSel == `CSS_SRC_PEER && ownMode == `CSS_MODE_NORMAL
      && peerMode == `CSS_MODE_NORMAL && $rose(peer_match1_flag);
   endsequence

   chk_peer_normal_edge: assert property (@(posedge clock) disable iff (!resetn)
      peerRise |=> countPulse)
      else $error("peer flag edge not counted");

   chk_peer_pwm_edge: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel == `CSS_SRC_PEER && ownMode == `CSS_MODE_NORMAL && peerMode == `CSS_MODE_PWM
       && $rose(peerCoinOut1)) |=> countPulse)
      else $error("peer output edge not counted");

   chk_peer_bad_mode: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel == `CSS_SRC_PEER && ownMode != `CSS_MODE_NORMAL) |=> !countPulse && srcIllegal)
      else $error("peer source used in wrong mode");

   chk_int_only_normal: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel inside {`CSS_SRC_INT0, `CSS_SRC_INT1, `CSS_SRC_INT2, `CSS_SRC_INT3}
       && ownMode != `CSS_MODE_NORMAL) |=> !countPulse)
      else $error("internal clock counted outside normal mode");

   chk_phase_bad_mode: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel == `CSS_SRC_PHASE && (ownMode == `CSS_MODE_PULSE || ownMode == `CSS_MODE_PWM))
      |=> !countPulse)
      else $error("phase source counted in wrong mode");

   chk_int0_tick: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel == `CSS_SRC_INT0 && ownMode == `CSS_MODE_NORMAL && tk.tick[0])
      |=> countPulse)
      else $error("tick not counted");

   chk_phase_up_edge: assert property (@(posedge clock) disable iff (!resetn)
      ($stable(srcSel) && srcSel == `CSS_SRC_PHASE && ownMode == `CSS_MODE_NORMAL
       && pulseMode == `CSS_PIM_1X1A && !countDownCmd && $rose(phaseA))
      |=> ##2 countPulse && !countDown)
      else $error("phase A rise not counted up");

   chk_single_pulse: assert property (@(posedge clock) disable iff (!resetn)
      (srcSel == `CSS_SRC_PEER && $stable(srcSel) && countPulse) |=> !countPulse)
      else $error("peer edge counted twice");
endmodule : css_source_select

`default_nettype wire

// ===== tb/css_pulse_src.sv
/*
 * Model of the external pulse source that drives the phase A/B pins.
 * Assumes the bench calls drive() from one process at a time.
 */
`timescale 1ns/10ps
`default_nettype none

module css_pulse_src (
   // Clock
   input wire logic  clock,
   // Pins
   output var logic  phaseA,
   output var logic  phaseB
);
   // The encoder drives push-pull, so both pins always hold a level.
   initial begin
      phaseA = 1'b0;
      phaseB = 1'b0;
   end

   // Each level is held four cycles: shorter levels could slip past the sampler.
   task automatic drive(input logic onA, input logic v);
      @(posedge clock);
      #1;
      if (onA) begin
         phaseA = v;
      end else begin
         phaseB = v;
      end
      repeat (3) @(posedge clock);
   endtask : drive
endmodule : css_pulse_src

`default_nettype wire

// ===== tb/testbench.sv
/*
 * Self-checking bench of the count-source selector.
 * Assumes css_pkg and css_cfg.svh are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none
`include "css_cfg.svh"

module testbench;
   logic                  clock;
   logic                  resetn;
   css_pkg::css_src_type  srcSel;
   css_pkg::css_mode_type ownMode;
   css_pkg::css_mode_type peerMode;
   css_pkg::css_pim_type  pulseMode;
   logic                  countDownCmd;
   logic                  peer_match1_flag;
   logic                  peerCoinOut1;
   wire logic             phaseA;
   wire logic             phaseB;
   wire logic             countPulse;
   wire logic             countDown;
   wire logic             srcIllegal;
   int                    n_mismatch;
   int                    total_checks;
   int                    nPulse;
   int                    nDown;

   css_pulse_src enc (.clock(clock), .phaseA(phaseA), .phaseB(phaseB));

   css_source_select dut (
      .clock(clock), .resetn(resetn), .srcSel(srcSel), .ownMode(ownMode),
      .peerMode(peerMode), .pulseMode(pulseMode), .countDownCmd(countDownCmd),
      .phaseA(phaseA), .phaseB(phaseB), .peer_match1_flag(peer_match1_flag),
      .peerCoinOut1(peerCoinOut1), .countPulse(countPulse),
      .countDown(countDown), .srcIllegal(srcIllegal));

   // 200 MHz clock.
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // Counting high cycles also catches a pulse that stands too long; the
   // falling edge keeps the tally clear of checks made on rising edges.
   always @(negedge clock) begin
      if (countPulse === 1'b1) nPulse++;
      if (countPulse === 1'b1 && countDown === 1'b1) nDown++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : close_out

   task automatic cfg(input logic [2:0] s, input logic [2:0] o, input logic [2:0] p,
                      input logic [2:0] m);
      @(posedge clock);
      #1;
      srcSel = s;
      ownMode = o;
      peerMode = p;
      pulseMode = m;
      repeat (4) @(posedge clock);
      #1;
      nPulse = 0;
      nDown = 0;
   endtask : cfg

   task automatic hold(input logic [1:0] v, input int n);
      @(posedge clock);
      #1;
      {peer_match1_flag, peerCoinOut1} = v;
      repeat (n - 1) @(posedge clock);
   endtask : hold

   // Peer source: only the signal chosen by the peer's mode may count.
   task automatic t_peer(input logic pwm);
      cfg(`CSS_SRC_PEER, `CSS_MODE_NORMAL, pwm ? `CSS_MODE_PWM : `CSS_MODE_NORMAL, 3'h0);
      hold(pwm ? 2'b10 : 2'b01, 3);
      hold(2'b00, 4);
      check(nPulse, 0);
      hold(pwm ? 2'b01 : 2'b10, 2);
      hold(2'b00, 1);
      hold(pwm ? 2'b01 : 2'b10, 3);
      hold(2'b00, 4);
      check(nPulse, 2);
   endtask : t_peer

   // Each tick source over a whole number of periods; direction, pulse mode and
   // pin edges, which arrive every four cycles, must all be ignored.
   task automatic t_ticks();
      int per[4] = '{20, 200, 2000, 20000};
      int cnt[4] = '{20, 5, 3, 1};
      #1;
      countDownCmd = 1'b1;
      for (int i = 0; i < 4; i++) begin
         cfg(`CSS_SRC_INT0 + 3'(i), `CSS_MODE_NORMAL, `CSS_MODE_PWM, `CSS_PIM_2X4);
         repeat (per[i] * cnt[i] / 8) begin
            enc.drive(1, 1);
            enc.drive(1, 0);
         end
         check(nPulse, cnt[i]);
         check(nDown, 0);
      end
      #1;
      countDownCmd = 1'b0;
   endtask : t_ticks

   // Pin decoding: A-only x1 drops the wrong-direction edge; x4 quadrature.
   task automatic t_phase();
      cfg(`CSS_SRC_PHASE, `CSS_MODE_NORMAL, `CSS_MODE_NORMAL, `CSS_PIM_1X1A);
      enc.drive(1, 1);
      enc.drive(1, 0);
      #1;
      countDownCmd = 1'b1;
      enc.drive(1, 1);
      enc.drive(1, 0);
      repeat (4) @(posedge clock);
      check(nPulse, 2);
      check(nDown, 1);
      #1;
      countDownCmd = 1'b0;
      cfg(`CSS_SRC_PHASE, `CSS_MODE_FREQ, `CSS_MODE_NORMAL, `CSS_PIM_2X4);
      enc.drive(1, 1);
      enc.drive(0, 1);
      enc.drive(1, 0);
      enc.drive(0, 0);
      repeat (4) @(posedge clock);
      check(nPulse, 4);
      check(nDown, 0);
      cfg(`CSS_SRC_PHASE, `CSS_MODE_SPEED, `CSS_MODE_NORMAL, `CSS_PIM_2X4);
      check(srcIllegal, 0);
      enc.drive(0, 1);
      enc.drive(1, 1);
      enc.drive(0, 0);
      enc.drive(1, 0);
      repeat (4) @(posedge clock);
      check(nPulse, 4);
      check(nDown, 4);
   endtask : t_phase

   // Every pulse mode over one fixed A/B walk; counts follow each mode's edge rules.
   task automatic t_modes();
      int expP[8] = '{2, 2, 4, 4, 2, 2, 4, 6};
      int expD[8] = '{1, 0, 2, 0, 1, 1, 2, 3};
      for (int m = 0; m < 8; m++) begin
         cfg(`CSS_SRC_PHASE, `CSS_MODE_NORMAL, `CSS_MODE_NORMAL, 3'(m));
         enc.drive(1, 1);
         enc.drive(1, 0);
         enc.drive(0, 1);
         enc.drive(1, 1);
         enc.drive(1, 0);
         enc.drive(0, 0);
         repeat (4) @(posedge clock);
         check(nPulse, expP[m]);
         check(nDown, expD[m]);
      end
   endtask : t_modes

   // Refused pairs raise the flag and count nothing even with events present.
   task automatic t_illegal();
      logic [9:0] tb[8] = '{
         {`CSS_SRC_PHASE, `CSS_MODE_PULSE, `CSS_MODE_NORMAL, 1'b1},
         {`CSS_SRC_PHASE, `CSS_MODE_PWM, `CSS_MODE_NORMAL, 1'b1},
         {`CSS_SRC_PHASE, `CSS_MODE_FREQ, `CSS_MODE_NORMAL, 1'b0},
         {`CSS_SRC_INT0, `CSS_MODE_FREQ, `CSS_MODE_NORMAL, 1'b1},
         {`CSS_SRC_INT3, `CSS_MODE_SPEED, `CSS_MODE_NORMAL, 1'b1},
         {`CSS_SRC_PEER, `CSS_MODE_NORMAL, `CSS_MODE_PWM, 1'b0},
         {`CSS_SRC_PEER, `CSS_MODE_NORMAL, `CSS_MODE_FREQ, 1'b1},
         {`CSS_SRC_PEER, `CSS_MODE_PWM, `CSS_MODE_NORMAL, 1'b1}};
      for (int i = 0; i < 8; i++) begin
         cfg(tb[i][9:7], tb[i][6:4], tb[i][3:1], 3'h0);
         check(srcIllegal, tb[i][0]);
         hold(2'b11, 60);
         hold(2'b00, 3);
         if (tb[i][0]) begin
            check(nPulse, 0);
         end else begin
            check(nPulse, (tb[i][9:7] == `CSS_SRC_PEER) ? 32'h1 : 32'h0);
         end
      end
   endtask : t_illegal

   // Hang guard, well past the roughly 150 us the sequence needs.
   initial begin
      #400000;
      n_mismatch++;
      close_out();
   end

   initial begin
      resetn = 1'b0;
      srcSel = `CSS_SRC_PHASE;
      ownMode = `CSS_MODE_NORMAL;
      peerMode = `CSS_MODE_NORMAL;
      pulseMode = `CSS_PIM_1X1;
      countDownCmd = 1'b0;
      peer_match1_flag = 1'b0;
      peerCoinOut1 = 1'b0;
      n_mismatch = 0;
      total_checks = 0;
      nPulse = 0;
      nDown = 0;
      repeat (12) @(posedge clock);
      #1;
      resetn = 1'b1;
      t_peer(1'b0);
      t_peer(1'b1);
      t_phase();
      t_modes();
      t_illegal();
      t_ticks();
      close_out();
   end
endmodule : testbench

`default_nettype wire
